// File: bce_pkg.sv
`default_nettype none
package bce_pkg;
  // Register addresses on the serial link (6-bit address field)
  localparam logic [5:0] A_REF_XL = 6'h08;
  localparam logic [5:0] A_REF_L  = 6'h09;
  localparam logic [5:0] A_REF_H  = 6'h0A;
  localparam logic [5:0] A_CTRL1  = 6'h20;
  localparam logic [5:0] A_CTRL2  = 6'h21;
  localparam logic [5:0] A_PINCTL = 6'h22;
  localparam logic [5:0] A_EVCFG  = 6'h23;
  localparam logic [5:0] A_EVSRC  = 6'h24;
  localparam logic [5:0] A_THSL   = 6'h25;
  localparam logic [5:0] A_THSH   = 6'h26;
  localparam logic [5:0] A_STAT   = 6'h27;
  localparam logic [5:0] A_P_XL   = 6'h28;
  localparam logic [5:0] A_P_L    = 6'h29;
  localparam logic [5:0] A_P_H    = 6'h2A;
  localparam logic [5:0] A_T_L    = 6'h2B;
  localparam logic [5:0] A_T_H    = 6'h2C;
  localparam logic [5:0] A_ACK    = 6'h2F;
  // Reset value of every configuration byte
  localparam logic [7:0] RST_BYTE = 8'h00;
  // control_one fields
  localparam int C1_PD    = 7;
  localparam int C1_ODR   = 4;
  localparam int C1_CMP   = 3;
  localparam int C1_BDU   = 2;
  localparam int C1_WIRE  = 0;
  // control_two fields
  localparam int C2_TRIM  = 7;
  localparam int C2_SRST  = 2;
  localparam int C2_AZ    = 1;
  localparam int C2_ONE   = 0;
  // event_pin_control fields
  localparam int PC_POL   = 7;
  localparam int PC_DRV   = 6;
  localparam int PC_S2    = 3;
  localparam int PC_S1    = 0;
  // event_config fields
  localparam int EC_LATCH = 2;
  localparam int EC_LOW   = 1;
  localparam int EC_HIGH  = 0;
  // sample_status fields
  localparam int ST_T     = 0;
  localparam int ST_P     = 1;
  // Event pin source codes and the one-shot rate code
  localparam logic [2:0] SRC_GND    = 3'h0;
  localparam logic [2:0] SRC_HIGH   = 3'h1;
  localparam logic [2:0] SRC_LOW    = 3'h2;
  localparam logic [2:0] SRC_EITHER = 3'h3;
  localparam logic [2:0] SRC_READY  = 3'h4;
  localparam logic [2:0] SRC_TRI    = 3'h7;
  localparam logic [2:0] ODR_ONE    = 3'h0;
  // Trim reload sequencer
  typedef enum logic [1:0] {TR_IDLE, TR_WAIT, TR_LOAD} bce_trim_t;
endpackage
`default_nettype wire

// File: bce_regs.sv
// Behaviour
// - Lock off: results refresh on every sample
// - Lock on: freeze result until other part read
// - Wire mode: read data on out or shared pin
// - Control two bits layout, all reset zero
// - Trim reload copies trim, then self-clears
// - Trim reload acts after one rate tick
// - Soft reset plus trim restores power-on config
// - Auto-zero stores reference, output becomes difference
// - Rate 000: trigger starts one acquisition
// - Conversion end: load results, status, clear trigger
// - Pin control bit 7 sets polarity
// - Pin control bit 6 picks push-pull/open-drain
// - Three-bit source select per event pin
// - Ready source shows new pressure available
// - Event config: latch, low, high enables
// - Low event when pressure below threshold
// - High event when pressure above threshold
// - Threshold low byte, reset zero
// - Comparison only while compare enable set
`timescale 1ns/1ps
`default_nettype none
module bce_regs
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  // Serial port pins
  input  wire logic        CS_N_I,
  input  wire logic        SPC_I,
  input  wire logic        SDIO_I,
  output logic             SDIO_O,
  output logic             SDIO_OE_O,
  output logic             SDO_O,
  output logic             SDO_OE_O,
  // Event pins
  output logic             EVT1_O,
  output logic             EVT1_OE_O,
  output logic             EVT2_O,
  output logic             EVT2_OE_O,
  // Converter side
  input  wire logic        SMP_VALID_I,
  input  wire logic [23:0] SMP_PRESS_I,
  input  wire logic [15:0] SMP_TEMP_I,
  input  wire logic        ODR_TICK_I,
  input  wire logic        TRIM_DONE_I,
  output logic             CONV_START_O,
  output logic             TRIM_LOAD_O,
  output logic             POWER_UP_O,
  output logic [2:0]       RATE_SEL_O
);

  // Pin synchronisers and serial shift state
  logic       cs_n_s1, cs_n_s2, spc_s1, spc_s2, spc_s3, sdi_s1, sdi_s2;
  logic [2:0] bit_q;
  logic       hdr_q, rw_q, ms_q;
  logic [5:0] addr_q;
  logic [6:0] sh_q;
  logic [7:0] tx_q;
  // Register state
  logic [7:0]  ctrl1_q, pinctl_q, evcfg_q, thsl_q, thsh_q;
  logic        trim_q, srst_q, one_q, zero_on_q;
  logic [23:0] ref_q, raw_q, press_q;
  logic [15:0] temp_q;
  logic [1:0]  stat_q, flags_q;
  logic        plo_q, phi_q, tlo_q, thi_q;
  logic        conv_q, trim_load_q;
  logic [1:0]  evo_q, evoe_q;
  bce_pkg::bce_trim_t trim_st_q;

  // Serial decode
  logic        spc_rise, byte_end, drive, rd_stb, wr_stb;
  logic [5:0]  hdr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data;
  assign spc_rise = spc_s2 & ~spc_s3;
  assign byte_end = spc_rise & ~cs_n_s2 & (bit_q == 3'h7);
  assign hdr_addr = {sh_q[4:0], sdi_s2};
  assign rd_addr  = hdr_q ? (ms_q ? addr_q + 6'h01 : addr_q) : hdr_addr;
  assign rd_stb   = byte_end & (hdr_q ? rw_q : sh_q[6]);
  assign wr_stb   = byte_end & hdr_q & ~rw_q;
  assign wr_data  = {sh_q, sdi_s2};
  assign drive    = ~cs_n_s2 & hdr_q & rw_q;

  // Register access decode
  logic wr_c1, wr_c2, soft_rst, rd_ack, rd_plo, rd_phi, rd_tlo, rd_thi;
  assign wr_c1    = wr_stb & (addr_q == bce_pkg::A_CTRL1);
  assign wr_c2    = wr_stb & (addr_q == bce_pkg::A_CTRL2);
  assign soft_rst = wr_c2 & wr_data[bce_pkg::C2_TRIM] & wr_data[bce_pkg::C2_SRST];
  assign rd_ack   = rd_stb & (rd_addr == bce_pkg::A_ACK);
  assign rd_plo   = rd_stb & ((rd_addr == bce_pkg::A_P_XL) | (rd_addr == bce_pkg::A_P_L));
  assign rd_phi   = rd_stb & (rd_addr == bce_pkg::A_P_H);
  assign rd_tlo   = rd_stb & (rd_addr == bce_pkg::A_T_L);
  assign rd_thi   = rd_stb & (rd_addr == bce_pkg::A_T_H);

  // Sample path, freeze and comparison
  logic        block_update_lock, pfrz, tfrz, cmp_en, hi_ev, lo_ev;
  logic [23:0] diff;
  logic [16:0] ths_s;
  logic [1:0]  ev_new, flags_d;
  assign block_update_lock    = ctrl1_q[bce_pkg::C1_BDU];
  assign pfrz   = block_update_lock & (plo_q | phi_q);
  assign tfrz   = block_update_lock & (tlo_q | thi_q);
  assign diff   = SMP_PRESS_I - (zero_on_q ? ref_q : 24'h000000);
  assign ths_s  = {1'b0, thsh_q, thsl_q};
  assign cmp_en = ctrl1_q[bce_pkg::C1_CMP];
  assign hi_ev  = cmp_en & evcfg_q[bce_pkg::EC_HIGH]
                  & ($signed({diff[23], diff[23:8]}) > $signed(ths_s));
  assign lo_ev  = cmp_en & evcfg_q[bce_pkg::EC_LOW]
                  & ($signed({diff[23], diff[23:8]}) < $signed(ths_s));
  assign ev_new = SMP_VALID_I ? {lo_ev, hi_ev} : 2'h0;
  // Latched flags hold until acknowledge, a new event wins over the clear
  assign flags_d = evcfg_q[bce_pkg::EC_LATCH]
                   ? ((rd_ack ? 2'h0 : flags_q) | ev_new)
                   : (SMP_VALID_I ? ev_new : (rd_ack ? 2'h0 : flags_q));

  // Event pin source selection
  function automatic logic pin_src(input logic [2:0] sel, input logic [1:0] fl,
                                   input logic rdy);
    logic v;
    v = 1'b0;
    unique case (sel)
      bce_pkg::SRC_HIGH:   v = fl[0];
      bce_pkg::SRC_LOW:    v = fl[1];
      bce_pkg::SRC_EITHER: v = |fl;
      bce_pkg::SRC_READY:  v = rdy;
      default:             v = 1'b0;
    endcase
    return v;
  endfunction

  logic [1:0] src_lvl, pin_tri, pin_act;
  assign src_lvl[0] = pin_src(pinctl_q[bce_pkg::PC_S1 +: 3], flags_q, stat_q[bce_pkg::ST_P]);
  assign src_lvl[1] = pin_src(pinctl_q[bce_pkg::PC_S2 +: 3], flags_q, stat_q[bce_pkg::ST_P]);
  assign pin_tri[0] = pinctl_q[bce_pkg::PC_S1 +: 3] == bce_pkg::SRC_TRI;
  assign pin_tri[1] = pinctl_q[bce_pkg::PC_S2 +: 3] == bce_pkg::SRC_TRI;
  assign pin_act    = src_lvl ^ {2{pinctl_q[bce_pkg::PC_POL]}};

  // Read data selection
  always_comb
  begin
    rd_data = 8'h00;
    unique case (rd_addr)
      bce_pkg::A_REF_XL: rd_data = ref_q[7:0];
      bce_pkg::A_REF_L:  rd_data = ref_q[15:8];
      bce_pkg::A_REF_H:  rd_data = ref_q[23:16];
      bce_pkg::A_CTRL1:  rd_data = ctrl1_q;
      bce_pkg::A_CTRL2:  rd_data = {trim_q, 4'h0, srst_q, 1'b0, one_q};
      bce_pkg::A_PINCTL: rd_data = pinctl_q;
      bce_pkg::A_EVCFG:  rd_data = {5'h00, evcfg_q[2:0]};
      bce_pkg::A_EVSRC:  rd_data = {5'h00, |flags_q, flags_q};
      bce_pkg::A_THSL:   rd_data = thsl_q;
      bce_pkg::A_THSH:   rd_data = thsh_q;
      bce_pkg::A_STAT:   rd_data = {6'h00, stat_q};
      bce_pkg::A_P_XL:   rd_data = press_q[7:0];
      bce_pkg::A_P_L:    rd_data = press_q[15:8];
      bce_pkg::A_P_H:    rd_data = press_q[23:16];
      bce_pkg::A_T_L:    rd_data = temp_q[7:0];
      bce_pkg::A_T_H:    rd_data = temp_q[15:8];
      default:           rd_data = 8'h00;
    endcase
  end

  // Pin synchronisers
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      {cs_n_s1, cs_n_s2} <= 2'h3;
      {spc_s1, spc_s2, spc_s3} <= 3'h7;
      {sdi_s1, sdi_s2} <= 2'h0;
    end
    else
    begin
      {cs_n_s1, cs_n_s2} <= {CS_N_I, cs_n_s1};
      {spc_s1, spc_s2, spc_s3} <= {SPC_I, spc_s1, spc_s2};
      {sdi_s1, sdi_s2} <= {SDIO_I, sdi_s1};
    end
  end

  // Serial shifter: header byte, then data bytes sampled on rising clock
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      bit_q  <= 3'h0;
      hdr_q  <= 1'b0;
      rw_q   <= 1'b0;
      ms_q   <= 1'b0;
      addr_q <= 6'h00;
      sh_q   <= 7'h00;
      tx_q   <= 8'h00;
    end
    else if (cs_n_s2)
    begin
      bit_q <= 3'h0;
      hdr_q <= 1'b0;
    end
    else if (spc_rise)
    begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= {sh_q[5:0], sdi_s2};
      tx_q  <= rd_stb ? rd_data : {tx_q[6:0], 1'b0};
      if (bit_q == 3'h7)
      begin
        hdr_q  <= 1'b1;
        rw_q   <= hdr_q ? rw_q : sh_q[6];
        ms_q   <= hdr_q ? ms_q : sh_q[5];
        addr_q <= hdr_q ? (ms_q ? addr_q + 6'h01 : addr_q) : hdr_addr;
      end
    end
  end

  // Configuration registers and self-clearing commands
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ctrl1_q <= bce_pkg::RST_BYTE;
      pinctl_q <= bce_pkg::RST_BYTE;
      evcfg_q <= bce_pkg::RST_BYTE;
      thsl_q <= bce_pkg::RST_BYTE;
      thsh_q <= bce_pkg::RST_BYTE;
      {trim_q, srst_q, one_q, zero_on_q, conv_q} <= 5'h00;
      ref_q <= 24'h000000;
    end
    else if (soft_rst)
    begin
      ctrl1_q <= bce_pkg::RST_BYTE;
      pinctl_q <= bce_pkg::RST_BYTE;
      evcfg_q <= bce_pkg::RST_BYTE;
      thsl_q <= bce_pkg::RST_BYTE;
      thsh_q <= bce_pkg::RST_BYTE;
      {trim_q, srst_q, one_q, zero_on_q, conv_q} <= 5'h00;
      ref_q <= 24'h000000;
    end
    else
    begin
      conv_q <= wr_c2 & wr_data[bce_pkg::C2_ONE]
                & (ctrl1_q[bce_pkg::C1_ODR +: 3] == bce_pkg::ODR_ONE);
      // Hardware clears first so a write of one in the same cycle wins
      if (trim_st_q == bce_pkg::TR_LOAD && TRIM_DONE_I)
        trim_q <= 1'b0;
      if (SMP_VALID_I)
        one_q <= 1'b0;
      if (wr_c1)
        ctrl1_q <= wr_data;
      if (wr_c2)
      begin
        srst_q <= wr_data[bce_pkg::C2_SRST];
        if (wr_data[bce_pkg::C2_TRIM])
          trim_q <= 1'b1;
        if (wr_data[bce_pkg::C2_ONE] && ctrl1_q[bce_pkg::C1_ODR +: 3] == bce_pkg::ODR_ONE)
          one_q <= 1'b1;
        if (wr_data[bce_pkg::C2_AZ])
        begin
          ref_q     <= raw_q;
          zero_on_q <= 1'b1;
        end
      end
      if (wr_stb && addr_q == bce_pkg::A_REF_XL) ref_q[7:0] <= wr_data;
      if (wr_stb && addr_q == bce_pkg::A_REF_L)  ref_q[15:8] <= wr_data;
      if (wr_stb && addr_q == bce_pkg::A_REF_H)  ref_q[23:16] <= wr_data;
      if (wr_stb && addr_q == bce_pkg::A_PINCTL) pinctl_q <= wr_data;
      if (wr_stb && addr_q == bce_pkg::A_EVCFG)  evcfg_q <= {5'h00, wr_data[2:0]};
      if (wr_stb && addr_q == bce_pkg::A_THSL)   thsl_q <= wr_data;
      if (wr_stb && addr_q == bce_pkg::A_THSH)   thsh_q <= wr_data;
    end
  end

  // Trim reload waits for the next rate tick, then requests the copy
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      trim_st_q   <= bce_pkg::TR_IDLE;
      trim_load_q <= 1'b0;
    end
    else
    begin
      trim_load_q <= 1'b0;
      unique case (trim_st_q)
        bce_pkg::TR_IDLE: if (trim_q && !soft_rst) trim_st_q <= bce_pkg::TR_WAIT;
        bce_pkg::TR_WAIT:
          if (ODR_TICK_I)
          begin
            trim_st_q   <= bce_pkg::TR_LOAD;
            trim_load_q <= 1'b1;
          end
        bce_pkg::TR_LOAD: if (TRIM_DONE_I) trim_st_q <= bce_pkg::TR_IDLE;
      endcase
    end
  end

  // Output results, lock tracking (idle while unlocked, no stale freeze), status, event flags
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      raw_q   <= 24'h000000;
      press_q <= 24'h000000;
      temp_q  <= 16'h0000;
      stat_q  <= 2'h0;
      flags_q <= 2'h0;
      {plo_q, phi_q, tlo_q, thi_q} <= 4'h0;
    end
    else
    begin
      flags_q <= flags_d;
      {plo_q, phi_q} <= (!block_update_lock || ((plo_q | rd_plo) & (phi_q | rd_phi))) ? 2'h0
                        : {plo_q | rd_plo, phi_q | rd_phi};
      {tlo_q, thi_q} <= (!block_update_lock || ((tlo_q | rd_tlo) & (thi_q | rd_thi))) ? 2'h0
                        : {tlo_q | rd_tlo, thi_q | rd_thi};
      stat_q[bce_pkg::ST_P] <= SMP_VALID_I | (stat_q[bce_pkg::ST_P] & ~rd_phi);
      stat_q[bce_pkg::ST_T] <= SMP_VALID_I | (stat_q[bce_pkg::ST_T] & ~rd_thi);
      if (SMP_VALID_I)
      begin
        raw_q <= SMP_PRESS_I;
        if (!pfrz) press_q <= diff;
        if (!tfrz) temp_q  <= SMP_TEMP_I;
      end
    end
  end

  // Event pin drivers: push-pull drives the level, open-drain only pulls low
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      evo_q  <= 2'h0;
      evoe_q <= 2'h0;
    end
    else if (pinctl_q[bce_pkg::PC_DRV])
    begin
      evo_q  <= 2'h0;
      evoe_q <= ~pin_tri & ~pin_act;
    end
    else
    begin
      evo_q  <= pin_act;
      evoe_q <= ~pin_tri;
    end
  end

  // Pin and converter outputs
  assign SDO_O        = tx_q[7];
  assign SDIO_O       = tx_q[7];
  assign SDO_OE_O     = drive & ~ctrl1_q[bce_pkg::C1_WIRE];
  assign SDIO_OE_O    = drive & ctrl1_q[bce_pkg::C1_WIRE];
  assign EVT1_O       = evo_q[0];
  assign EVT1_OE_O    = evoe_q[0];
  assign EVT2_O       = evo_q[1];
  assign EVT2_OE_O    = evoe_q[1];
  assign CONV_START_O = conv_q;
  assign TRIM_LOAD_O  = trim_load_q;
  assign POWER_UP_O   = ctrl1_q[bce_pkg::C1_PD];
  assign RATE_SEL_O   = ctrl1_q[bce_pkg::C1_ODR +: 3];

endmodule // bce_regs
`default_nettype wire

// File: bce_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module bce_regs_props
(
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RSTN_I,
  // Inputs watched
  input  wire logic       CS_N_I,
  input  wire logic       SMP_VALID_I,
  input  wire logic       ODR_TICK_I,
  // Outputs watched
  input  wire logic       SDIO_OE_O,
  input  wire logic       SDO_OE_O,
  input  wire logic       EVT1_O,
  input  wire logic       EVT1_OE_O,
  input  wire logic       EVT2_O,
  input  wire logic       CONV_START_O,
  input  wire logic       TRIM_LOAD_O,
  input  wire logic [2:0] RATE_SEL_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Data pin drive follows the frame and the wire mode
  a_one_data_pin: assert property (!(SDO_OE_O && SDIO_OE_O))
    else $error("both data pins driven");
  a_idle_released: assert property (CS_N_I [*6] |-> !SDO_OE_O && !SDIO_OE_O)
    else $error("data pin driven while deselected");
  a_header_quiet: assert property ($fell(CS_N_I) |-> (!SDO_OE_O && !SDIO_OE_O) [*8])
    else $error("data pin driven during header");
  // Trim and conversion strobes
  a_trim_on_tick: assert property (TRIM_LOAD_O |-> $past(ODR_TICK_I))
    else $error("trim start without rate tick");
  a_trim_single: assert property (TRIM_LOAD_O |=> !TRIM_LOAD_O)
    else $error("trim start longer than one cycle");
  a_conv_single: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("conversion start repeated");
  a_conv_rate: assert property (CONV_START_O |-> RATE_SEL_O == bce_pkg::ODR_ONE)
    else $error("conversion start outside one-shot rate");
  // Quiet outputs after reset and between samples
  a_reset_quiet: assert property ($rose(RSTN_I) |->
    !EVT1_OE_O && !CONV_START_O && !TRIM_LOAD_O)
    else $error("output active right after reset");
  a_pins_quiet: assert property (CS_N_I [*8] ##1 !SMP_VALID_I [*3]
    |-> $stable(EVT1_O) && $stable(EVT2_O) && $stable(EVT1_OE_O))
    else $error("event pin moved without sample or access");
endmodule // bce_regs_props
bind bce_regs bce_regs_props chk_u (.*);
`default_nettype wire

// File: bce_host.sv
`timescale 1ns/1ps
`default_nettype none
module bce_host
(
  // Clock and returned data
  input  wire logic clk_i,
  input  wire logic miso_i,
  // Serial lines to the device
  output var logic  cs_n_o,
  output var logic  spc_o,
  output var logic  mosi_o
);
  // Idle: deselected, clock high
  initial
  begin
    cs_n_o = 1'b1;
    spc_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame, header then one byte, MSB first, 160 ns clock
  task automatic xfer(input logic r, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    sh = {r, 1'b0, a, d};
    q = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      repeat (8) @(negedge clk_i);
      spc_o = 1'b0;
      // Released while reading: a pattern that keeps changing
      mosi_o = (r && i < 8) ? ~mosi_o : sh[i];
      repeat (8) @(negedge clk_i);
      spc_o = 1'b1;
      q = {q[6:0], miso_i};
    end
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // bce_host
`default_nettype wire

// File: bce_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bce_regs_tb;
  logic        clk, rst_n, smp_v, tick, tdone, wire3;
  logic        sdio_o, sdio_oe, sdo_o, sdo_oe, cs_n, spc, host_d;
  logic        e1, e1_oe, e2, e2_oe, conv, trim, pwr;
  logic [2:0]  rate;
  logic [23:0] press;
  logic [7:0]  rv, ex;
  wire         sdio_w, miso;
  int          errors = 0, checks = 0, conv_n = 0, trim_n = 0, n;
  // Levels on the shared and dedicated data lines
  assign sdio_w = sdio_oe ? sdio_o : host_d;
  assign miso = wire3 ? sdio_w : (sdo_oe ? sdo_o : ~sdo_o);
  bce_regs dut_u (.CLK_I(clk), .RSTN_I(rst_n), .CS_N_I(cs_n), .SPC_I(spc),
    .SDIO_I(sdio_w), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .SDO_O(sdo_o),
    .SDO_OE_O(sdo_oe), .EVT1_O(e1), .EVT1_OE_O(e1_oe), .EVT2_O(e2),
    .EVT2_OE_O(e2_oe), .SMP_VALID_I(smp_v), .SMP_PRESS_I(press),
    .SMP_TEMP_I(press[15:0]), .ODR_TICK_I(tick), .TRIM_DONE_I(tdone),
    .CONV_START_O(conv), .TRIM_LOAD_O(trim), .POWER_UP_O(pwr), .RATE_SEL_O(rate));
  bce_host host_u (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .spc_o(spc),
    .mosi_o(host_d));
  // Clock and strobe counters
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    conv_n += int'(conv);
    trim_n += int'(trim);
  end
  // Compare, access and sample helpers
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, rv);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    host_u.xfer(1'b1, a, 8'h00, rv);
    chk($sformatf("reg %h", a), rv, e);
  endtask
  task smp(input logic [23:0] p);
    press = p;
    smp_v = 1'b1;
    @(negedge clk);
    smp_v = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // Reset values, access kinds, wire modes
  task t_regs;
    for (int a = 33; a <= 37; a++)
      rd(6'(a), 8'h00);
    wr(6'h25, 8'hA5);
    wr(6'h23, 8'hFF);
    rd(6'h23, 8'h07);
    wr(6'h21, 8'h78);
    rd(6'h21, 8'h00);
    wr(6'h24, 8'hFF);
    rd(6'h24, 8'h00);
    wr(6'h20, 8'h01);
    wire3 = 1'b1;
    rd(6'h25, 8'hA5);
    wr(6'h20, 8'h00);
    wire3 = 1'b0;
    rd(6'h25, 8'hA5);
  endtask
  // One-shot conversion and trim reload
  task t_strobes;
    wr(6'h20, 8'h80);
    n = conv_n;
    wr(6'h21, 8'h01);
    chk("conv", 8'(conv_n - n), 8'h01);
    rd(6'h21, 8'h01);
    smp(24'h000100);
    rd(6'h21, 8'h00);
    rd(6'h27, 8'h03);
    wr(6'h20, 8'h90);
    chk("rate", {4'h0, pwr, rate}, 8'h09);
    wr(6'h21, 8'h01);
    chk("conv", 8'(conv_n - n), 8'h01);
    wr(6'h20, 8'h80);
    n = trim_n;
    wr(6'h21, 8'h80);
    chk("trim", 8'(trim_n - n), 8'h00);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (3) @(negedge clk);
    chk("trim", 8'(trim_n - n), 8'h01);
    rd(6'h21, 8'h80);
    tdone = 1'b1;
    @(negedge clk);
    tdone = 1'b0;
    rd(6'h21, 8'h00);
  endtask
  // Auto-zero, soft reset, update lock
  task t_data;
    smp(24'h123456);
    wr(6'h21, 8'h02);
    rd(6'h0A, 8'h12);
    smp(24'h123460);
    rd(6'h28, 8'h0A);
    wr(6'h25, 8'h33);
    wr(6'h21, 8'h84);
    rd(6'h25, 8'h00);
    rd(6'h08, 8'h00);
    wr(6'h20, 8'h84);
    smp(24'h111111);
    rd(6'h28, 8'h11);
    smp(24'h222222);
    rd(6'h2A, 8'h11);
    wr(6'h20, 8'h80);
    smp(24'h444444);
    rd(6'h2A, 8'h44);
    rd(6'h2B, 8'h44);
  endtask
  // Threshold events, pin sources, polarity, drive, latch
  task t_events;
    wr(6'h26, 8'h10);
    wr(6'h20, 8'h88);
    wr(6'h23, 8'h03);
    wr(6'h22, 8'h11);
    smp(24'h200000);
    chk("evt", {6'h00, e1, e2}, 8'h02);
    rd(6'h24, 8'h05);
    smp(24'h000100);
    for (int c = 0; c < 8; c++)
    begin
      wr(6'h22, {2'b00, 3'(c), 3'(c)});
      ex = {6'h00, c != 7, c inside {2, 3, 4}};
      chk("src", {6'h00, e1_oe, e1 & e1_oe}, ex);
    end
    wr(6'h22, 8'hD1);
    chk("od", {5'h00, e1_oe, e2_oe, e2}, 8'h02);
    wr(6'h22, 8'h91);
    chk("pol", {6'h00, e1_oe, e1}, 8'h03);
    wr(6'h23, 8'h07);
    smp(24'h200000);
    rd(6'h24, 8'h07);
    rd(6'h2F, 8'h00);
    rd(6'h24, 8'h00);
    wr(6'h20, 8'h80);
    wr(6'h23, 8'h03);
    smp(24'h200000);
    rd(6'h24, 8'h00);
  endtask
  // Verdict
  task close_out;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    smp_v = 1'b0;
    tick = 1'b0;
    tdone = 1'b0;
    wire3 = 1'b0;
    press = 24'h000000;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_regs;
    t_strobes;
    t_data;
    t_events;
    close_out;
  end
  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("Error run expected end seen hang");
    close_out;
  end
endmodule // bce_regs_tb
`default_nettype wire
